//--- include/sdram_pkg.sv
package sdram_pkg;

    // ------------------------------------------------------------
    // Widths and pin positions
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int BANK_BIT = 11;
    localparam int CLOSE_BIT = 10;
    localparam int SINGLE_WR_BIT = 9;
    localparam int LAT_HI = 6;
    localparam int LAT_LO = 4;
    localparam int BTYPE_BIT = 3;
    localparam int BLEN_HI = 2;
    localparam int OPT_HI = 11;
    localparam int OPT_LO = 7;

    // ------------------------------------------------------------
    // Mode field codes
    // ------------------------------------------------------------
    localparam logic [2:0] LAT_CODE_2 = 3'h2;
    localparam logic [2:0] LAT_CODE_3 = 3'h3;
    localparam logic [3:0] LAT_CLK_2 = 4'h2;
    localparam logic [3:0] LAT_CLK_3 = 4'h3;
    localparam logic [2:0] BLEN_CODE_1 = 3'h0;
    localparam logic [2:0] BLEN_CODE_2 = 3'h1;
    localparam logic [2:0] BLEN_CODE_4 = 3'h2;
    localparam logic [2:0] BLEN_CODE_8 = 3'h3;
    localparam logic [2:0] BLEN_CODE_PAGE = 3'h7;
    localparam logic [4:0] OPT_BURST_WR = 5'h00;
    localparam logic [4:0] OPT_SINGLE_WR = 5'h04;
    localparam logic [8:0] BURST_1 = 9'h001;
    localparam logic [8:0] BURST_2 = 9'h002;
    localparam logic [8:0] BURST_4 = 9'h004;
    localparam logic [8:0] BURST_8 = 9'h008;
    localparam logic [8:0] BURST_PAGE = 9'h100;
    localparam logic [11:0] MODE_RESET = 12'h020;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int PWRUP_US = 100;
    localparam int PWRUP_CYCLES = PWRUP_US * CLK_MHZ;
    localparam int MODE_GAP_CYCLES = 2;
    localparam int MIN_REFRESHES = 2;

    // ------------------------------------------------------------
    // Commands and bank states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        deselect_cmd, idle_cmd, burst_halt_cmd, read_cmd, write_cmd,
        row_open_cmd, all_banks_close_cmd, refresh_cmd, mode_load_cmd
    } cmd_e;

    // Pin codes: cs_n, ras_n, cas_n, we_n.
    localparam logic [3:0] PINS_NOP = 4'h7;
    localparam logic [3:0] PINS_HALT = 4'h6;
    localparam logic [3:0] PINS_READ = 4'h5;
    localparam logic [3:0] PINS_WRITE = 4'h4;
    localparam logic [3:0] PINS_ROW_OPEN = 4'h3;
    localparam logic [3:0] PINS_CLOSE = 4'h2;
    localparam logic [3:0] PINS_REFRESH = 4'h1;
    localparam logic [3:0] PINS_MODE = 4'h0;
    localparam logic [3:0] PINS_DESELECT = 4'hf;

    typedef enum logic [2:0] {
        bank_idle, bank_active, bank_read, bank_write,
        reading_autoclose_state, writing_autoclose_state
    } bank_state_e;

endpackage : sdram_pkg

//--- include/sdram_if.sv
`timescale 1ns/100ps
interface sdram_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] dqm;
    logic [11:0] addr;

    modport device (input cs_n, ras_n, cas_n, we_n, cke, dqm, addr);
    modport controller (output cs_n, ras_n, cas_n, we_n, cke, dqm, addr);
endinterface : sdram_if

//--- design/sdram_bank_tracker.sv
`timescale 1ns/100ps
// Functional notes
// - Four strobes decode nine commands, deselect first.
// - Row open uses row address, A11 bank.
// - Read/write column on low lines, A8/A9 ignored.
// - Read with A10 high auto-closes bank.
// - Write with A10 high auto-closes bank.
// - Close with A10 high idles both banks.
// - Mode load only with both banks idle.
// - Two idle cycles follow mode load.
// - Mode load captures A0..A11 as opcode.
// - Opcode: options, latency, burst type, length.
// - Hold clock enable, masks high 100us.
// - First command after hold closes all banks.
// - Two or more refreshes plus a mode load.
// - Mode load may precede the refreshes.
// - Banks idle before power-down or self-refresh; only self-refresh entry is flagged.
// - Clock enable rise wakes inputs at once.
// - Legal command whenever suspend starts non-idle.
// - Latency code 2 or 3 clocks, others reserved.
// - Burst length 1,2,4,8, full page sequential.
// - Burst type sequential 0, interleaved 1.
// - Option A9 alone selects single-word writes.
module sdram_bank_tracker (
    input wire logic sys_clk,
    input wire logic srst,
    sdram_if.device bus,
    output sdram_pkg::bank_state_e bank0_state,
    output sdram_pkg::bank_state_e bank1_state,
    output sdram_pkg::cmd_e last_cmd,
    output logic [7:0] col_addr,
    output logic [10:0] row_addr,
    output logic [11:0] mode_code,
    output logic [3:0] read_latency,
    output logic [8:0] burst_len,
    output logic burst_interleaved,
    output logic single_write,
    output logic mode_reserved,
    output logic protocol_error
);
    import sdram_pkg::*;

    // ------------------------------------------------------------
    // Pin capture
    // ------------------------------------------------------------
    // The clock enable freezes the command pins; its rising edge is taken
    // as live in the same cycle, modelling the asynchronous wake-up.
    logic cke_q;
    wire logic cmd_live = bus.cke;
    wire logic [3:0] pins = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    wire logic sel_bank = bus.addr[BANK_BIT];
    wire logic a10 = bus.addr[CLOSE_BIT];

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    cmd_e cmd;
    always_comb begin
        if (!cmd_live || bus.cs_n) begin
            cmd = deselect_cmd;
        end else begin
            unique case (pins[2:0])
                3'h7: cmd = idle_cmd;
                3'h6: cmd = burst_halt_cmd;
                3'h5: cmd = read_cmd;
                3'h4: cmd = write_cmd;
                3'h3: cmd = row_open_cmd;
                3'h2: cmd = all_banks_close_cmd;
                3'h1: cmd = refresh_cmd;
                3'h0: cmd = mode_load_cmd;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-bank next state
    // ------------------------------------------------------------
    // A read or write on one bank cuts short a read or write burst without auto-close still running in the other bank,
    // which then falls back to row-active.
    function automatic bank_state_e bank_next(bank_state_e cur, cmd_e c, logic hit, logic close_all);
        bank_state_e n;
        logic live_row;
        logic bursting;
        n = cur;
        live_row = hit && cur != bank_idle;
        bursting = cur == bank_read || cur == bank_write;
        unique case (c)
            row_open_cmd: begin
                if (hit && cur == bank_idle) begin
                    n = bank_active;
                end
            end
            read_cmd: begin
                if (live_row && close_all) begin
                    n = reading_autoclose_state;
                end else if (live_row) begin
                    n = bank_read;
                end else if (!hit && bursting) begin
                    n = bank_active;
                end
            end
            write_cmd: begin
                if (live_row && close_all) begin
                    n = writing_autoclose_state;
                end else if (live_row) begin
                    n = bank_write;
                end else if (!hit && bursting) begin
                    n = bank_active;
                end
            end
            all_banks_close_cmd: begin
                if (hit || close_all) begin
                    n = bank_idle;
                end
            end
            burst_halt_cmd: begin
                if (bursting) begin
                    n = bank_active;
                end
            end
            default: n = cur;
        endcase
        return n;
    endfunction : bank_next

    wire logic hit0 = !sel_bank;
    wire logic hit1 = sel_bank;
    wire bank_state_e next_bank0 = bank_next(bank0_state, cmd, hit0, a10);
    wire bank_state_e next_bank1 = bank_next(bank1_state, cmd, hit1, a10);
    wire logic both_idle = bank0_state == bank_idle && bank1_state == bank_idle;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire logic [2:0] lat_code = mode_code[LAT_HI:LAT_LO];
    wire logic [2:0] len_code = mode_code[BLEN_HI:0];
    wire logic [4:0] opt_code = mode_code[OPT_HI:OPT_LO];
    wire logic lat_ok = lat_code == LAT_CODE_2 || lat_code == LAT_CODE_3;
    wire logic len_page = len_code == BLEN_CODE_PAGE;
    wire logic len_ok = len_code <= BLEN_CODE_8 || (len_page && !mode_code[BTYPE_BIT]);
    wire logic opt_ok = opt_code == OPT_BURST_WR || opt_code == OPT_SINGLE_WR;

    always_comb begin
        read_latency = (lat_code == LAT_CODE_3) ? LAT_CLK_3 : LAT_CLK_2;
        unique case (len_code)
            BLEN_CODE_1: burst_len = BURST_1;
            BLEN_CODE_2: burst_len = BURST_2;
            BLEN_CODE_4: burst_len = BURST_4;
            BLEN_CODE_8: burst_len = BURST_8;
            BLEN_CODE_PAGE: burst_len = BURST_PAGE;
            default: burst_len = BURST_1;
        endcase
    end
    assign burst_interleaved = mode_code[BTYPE_BIT];
    assign single_write = opt_code == OPT_SINGLE_WR;
    assign mode_reserved = !(lat_ok && len_ok && opt_ok);

    // ------------------------------------------------------------
    // Misuse flags from the controller side
    // ------------------------------------------------------------
    logic [1:0] gap_cnt;
    wire logic mode_when_busy = cmd == mode_load_cmd && !both_idle;
    wire logic cmd_in_gap = gap_cnt != 2'h0 && cmd != deselect_cmd && cmd != idle_cmd;
    wire logic sleep_when_busy = cke_q && !bus.cke && bus.cs_n == 1'b0 && pins[2:0] == PINS_REFRESH[2:0]
                                 && !both_idle;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bank0_state <= bank_idle;
            bank1_state <= bank_idle;
            last_cmd <= deselect_cmd;
            cke_q <= 1'b1;
        end else begin
            bank0_state <= next_bank0;
            bank1_state <= next_bank1;
            last_cmd <= cmd;
            cke_q <= bus.cke;
        end
    end

    // ------------------------------------------------------------
    // Address capture
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            col_addr <= 8'h00;
            row_addr <= 11'h000;
        end else begin
            if (cmd == row_open_cmd) begin
                row_addr <= bus.addr[BANK_BIT-1:0];
            end
            if (cmd == read_cmd || cmd == write_cmd) begin
                col_addr <= bus.addr[COL_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Mode register, gap counter and misuse flag
    // ------------------------------------------------------------
    // A refused mode load still opens a gap, so the controller is held to the same spacing
    // whether or not its load was stored. The error flag stays up until reset.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_code <= MODE_RESET;
            gap_cnt <= 2'h0;
            protocol_error <= 1'b0;
        end else begin
            if (cmd == mode_load_cmd && both_idle) begin
                mode_code <= bus.addr;
            end
            if (cmd == mode_load_cmd) begin
                gap_cnt <= 2'(MODE_GAP_CYCLES);
            end else if (gap_cnt != 2'h0 && cmd_live) begin
                gap_cnt <= gap_cnt - 2'h1;
            end
            if (mode_when_busy || cmd_in_gap || sleep_when_busy) begin
                protocol_error <= 1'b1;
            end
        end
    end

endmodule : sdram_bank_tracker

//--- design/sdram_init_controller.sv
`timescale 1ns/100ps
module sdram_init_controller
#(
    parameter int PWRUP_CLKS = sdram_pkg::PWRUP_CYCLES,
    parameter int REFRESH_COUNT = sdram_pkg::MIN_REFRESHES,
    parameter bit MODE_FIRST = 1'b0
)
(
    input wire logic sys_clk,
    input wire logic srst,
    sdram_if.controller bus,
    input wire logic [11:0] mode_value,
    input wire logic user_valid,
    input wire logic [3:0] user_pins,
    input wire logic [11:0] user_addr,
    input wire logic user_cke,
    output logic user_ready,
    output logic init_done
);
    import sdram_pkg::*;

    // The refresh counter is four bits wide, so longer refresh runs are refused.
    if (REFRESH_COUNT < MIN_REFRESHES || REFRESH_COUNT > 15 || PWRUP_CLKS < 1) begin : gen_bad_params
        $error("sdram_init_controller: bad parameters");
    end

    localparam logic [11:0] CLOSE_ALL_ADDR = 12'(1) << CLOSE_BIT;

    typedef enum logic [2:0] {st_hold, st_close, st_refresh, st_mode, st_gap, st_run} init_e;
    init_e state;
    init_e next_state;
    logic [31:0] cnt;
    logic [3:0] refs;
    logic mode_done;

    // ------------------------------------------------------------
    // Sequence step selection
    // ------------------------------------------------------------
    wire logic hold_over = cnt == 32'(PWRUP_CLKS - 1);
    wire logic refs_done = refs == 4'(REFRESH_COUNT - 1);
    wire logic gap_over = cnt == 32'(MODE_GAP_CYCLES - 1);

    always_comb begin
        next_state = state;
        unique case (state)
            st_hold: if (hold_over) next_state = st_close;
            st_close: next_state = MODE_FIRST ? st_mode : st_refresh;
            st_refresh: if (refs_done) next_state = mode_done ? st_run : st_mode;
            st_mode: next_state = st_gap;
            st_gap: if (gap_over) next_state = MODE_FIRST ? st_refresh : st_run;
            st_run: next_state = st_run;
        endcase
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic [3:0] pins;
    logic [11:0] addr_q;
    logic cke_q;
    wire logic running = state == st_run;
    assign user_ready = running;
    assign init_done = running;
    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = pins;
    assign bus.addr = addr_q;
    assign bus.cke = cke_q;
    assign bus.dqm = {2{!running}};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= st_hold;
            cnt <= 32'h0000_0000;
            refs <= 4'h0;
            mode_done <= 1'b0;
            pins <= PINS_DESELECT;
            addr_q <= 12'h000;
            cke_q <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= (next_state != state) ? 32'h0000_0000 : cnt + 32'h0000_0001;
            pins <= PINS_NOP;
            addr_q <= 12'h000;
            cke_q <= 1'b1;
            if (state == st_refresh) begin
                refs <= refs + 4'h1;
            end
            unique case (next_state)
                st_close: begin
                    pins <= PINS_CLOSE;
                    addr_q <= CLOSE_ALL_ADDR;
                end
                st_refresh: if (state != st_gap || !refs_done) pins <= PINS_REFRESH;
                st_mode: begin
                    pins <= PINS_MODE;
                    addr_q <= mode_value;
                    mode_done <= 1'b1;
                end
                st_run: if (running) begin
                    // A command held while clock enable drops stays legal.
                    pins <= user_valid ? user_pins : PINS_NOP;
                    addr_q <= user_addr;
                    cke_q <= user_cke;
                end
                default: pins <= PINS_NOP;
            endcase
        end
    end

endmodule : sdram_init_controller

//--- verification/sdram_link_monitor.sv
`timescale 1ns/100ps
module sdram_link_monitor #(
    parameter int PWRUP_CLKS = sdram_pkg::PWRUP_CYCLES,
    parameter bit MODE_FIRST = 1'b0
)
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [1:0] dqm,
    input wire logic [11:0] addr
);
    // ------------------------------------------------------------
    // Command decode and init progress
    // ------------------------------------------------------------
    logic [15:0] cyc;
    logic [1:0] ref_cnt;
    logic seen_cmd;
    logic mode_seen;
    logic open0;
    logic open1;
    wire logic [2:0] code = {ras_n, cas_n, we_n};
    wire logic sel = !cs_n && cke;
    wire logic is_mode = sel && code == 3'b000;
    wire logic is_ref = sel && code == 3'b001;
    wire logic is_close = sel && code == 3'b010;
    wire logic is_open = sel && code == 3'b011;
    wire logic is_real = sel && code != 3'b111;
    // Busy means a row was opened and not yet closed; auto-close states count as busy.
    wire logic next_open0 = (is_open && !addr[11]) ? 1'b1 : ((is_close && (addr[10] || !addr[11])) ? 1'b0 : open0);
    wire logic next_open1 = (is_open && addr[11]) ? 1'b1 : ((is_close && (addr[10] || addr[11])) ? 1'b0 : open1);
    wire logic [15:0] next_cyc = (cyc == 16'hffff) ? cyc : cyc + 16'h0001;
    wire logic [1:0] next_ref_cnt = (is_ref && ref_cnt != 2'h3) ? ref_cnt + 2'h1 : ref_cnt;

    always_ff @(posedge sys_clk) begin
        cyc <= srst ? 16'h0000 : next_cyc;
        ref_cnt <= srst ? 2'h0 : next_ref_cnt;
        seen_cmd <= !srst && (seen_cmd || is_real);
        mode_seen <= !srst && (mode_seen || is_mode);
        open0 <= !srst && next_open0;
        open1 <= !srst && next_open1;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence quiet_s;
        cs_n || code == 3'b111;
    endsequence
    sequence close_all_s;
        is_close && addr[10];
    endsequence

    reset_pins_a: assert property ($fell(srst) |-> cs_n && cke && dqm == 2'b11)
        else $error("pins not parked after reset");
    hold_quiet_a: assert property (is_real |-> int'(cyc) >= PWRUP_CLKS - 1)
        else $error("command during power-up hold");
    init_pins_a: assert property (!mode_seen |-> cke && dqm == 2'b11)
        else $error("clock enable or masks low during init");
    first_close_a: assert property (is_real && !seen_cmd |-> close_all_s)
        else $error("first command is not a close of both banks");
    mode_after_ref_a: assert property (is_mode && !mode_seen |-> MODE_FIRST || ref_cnt >= 2'h2)
        else $error("mode load before two refreshes");
    run_after_init_a: assert property (is_open |-> mode_seen && ref_cnt >= 2'h2)
        else $error("row opened before init finished");
    mode_gap_a: assert property (is_mode |=> quiet_s [*2])
        else $error("command too soon after mode load");
    mode_idle_a: assert property (is_mode |-> !open0 && !open1)
        else $error("mode load with a busy bank");
    sleep_idle_a: assert property ($fell(cke) && !cs_n && code == 3'b001 |-> !open0 && !open1)
        else $error("self-refresh entered with a busy bank");
endmodule : sdram_link_monitor

//--- verification/sdram_command_bank_state_test.sv
`timescale 1ns/100ps
module sdram_command_bank_state_test;
    import sdram_pkg::*;
    localparam int HOLD = 20;
    localparam logic [11:0] MODE_VAL = 12'h23b;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic user_valid = 1'b0;
    logic [3:0] user_pins = PINS_NOP;
    logic [11:0] user_addr = 12'h000;
    logic user_cke = 1'b1;
    logic user_ready, init_done;
    bank_state_e bank0_state, bank1_state;
    cmd_e last_cmd;
    logic [7:0] col_addr;
    logic [10:0] row_addr;
    logic [11:0] mode_code;
    logic [3:0] read_latency;
    logic [8:0] burst_len;
    logic burst_interleaved, single_write, mode_reserved, protocol_error;
    int fail_count = 0;
    int n_tests = 0;

    always #10 sys_clk = ~sys_clk;

    sdram_if link();
    sdram_init_controller #(.PWRUP_CLKS(HOLD)) sdram_init_controller_inst (.sys_clk(sys_clk), .srst(srst),
        .bus(link), .mode_value(MODE_VAL), .user_valid(user_valid), .user_pins(user_pins),
        .user_addr(user_addr), .user_cke(user_cke), .user_ready(user_ready), .init_done(init_done));
    sdram_bank_tracker sdram_bank_tracker_inst (.sys_clk(sys_clk), .srst(srst), .bus(link),
        .bank0_state(bank0_state), .bank1_state(bank1_state), .last_cmd(last_cmd), .col_addr(col_addr),
        .row_addr(row_addr), .mode_code(mode_code), .read_latency(read_latency), .burst_len(burst_len),
        .burst_interleaved(burst_interleaved), .single_write(single_write),
        .mode_reserved(mode_reserved), .protocol_error(protocol_error));
    sdram_link_monitor #(.PWRUP_CLKS(HOLD)) sdram_link_monitor_inst (.sys_clk(sys_clk), .srst(srst),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke),
        .dqm(link.dqm), .addr(link.addr));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check_val(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_state(input string what, input bank_state_e exp, input bank_state_e got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %s seen %s", what, exp.name(), got.name());
        end
    endtask : check_state

    task automatic check_cmd(input string what, input cmd_e exp, input cmd_e got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %s seen %s", what, exp.name(), got.name());
        end
    endtask : check_cmd

    // The command needs one edge to reach the pins and one more to land in the tracker.
    task automatic issue(input logic [3:0] pins, input logic [11:0] a, input cmd_e exp);
        @(negedge sys_clk);
        user_valid = 1'b1;
        user_pins = pins;
        user_addr = a;
        @(negedge sys_clk);
        user_valid = 1'b0;
        user_pins = PINS_NOP;
        @(negedge sys_clk);
        check_cmd("last_cmd", exp, last_cmd);
        repeat (2) @(negedge sys_clk);
    endtask : issue

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_init;
        for (int i = 0; i < 200 && init_done !== 1'b1; i++) @(negedge sys_clk);
        check_val("init_done", 12'h001, 12'(init_done));
        check_val("user_ready", 12'h001, 12'(user_ready));
        check_val("mode_code", MODE_VAL, mode_code);
        check_val("read_latency", 12'(LAT_CLK_3), 12'(read_latency));
        check_val("burst_len", 12'(BURST_8), 12'(burst_len));
        check_val("burst_interleaved", 12'h001, 12'(burst_interleaved));
        check_val("single_write", 12'h001, 12'(single_write));
        check_val("mode_reserved", 12'h000, 12'(mode_reserved));
    endtask : test_init

    task automatic test_open_read;
        issue(PINS_ROW_OPEN, 12'hda5, row_open_cmd);
        check_state("bank1", bank_active, bank1_state);
        check_state("bank0", bank_idle, bank0_state);
        check_val("row_addr", 12'h5a5, 12'(row_addr));
        issue(PINS_READ, 12'ha55, read_cmd);
        check_state("bank1", bank_read, bank1_state);
        check_val("col_addr", 12'h055, 12'(col_addr));
        issue(PINS_READ, 12'hf3c, read_cmd);
        check_state("bank1", reading_autoclose_state, bank1_state);
        check_val("col_addr", 12'h03c, 12'(col_addr));
    endtask : test_open_read

    task automatic test_close_one;
        issue(PINS_ROW_OPEN, 12'h0a3, row_open_cmd);
        check_state("bank0", bank_active, bank0_state);
        issue(PINS_CLOSE, 12'h800, all_banks_close_cmd);
        check_state("bank1", bank_idle, bank1_state);
        check_state("bank0", bank_active, bank0_state);
    endtask : test_close_one

    task automatic test_write_halt;
        issue(PINS_WRITE, 12'h011, write_cmd);
        check_state("bank0", bank_write, bank0_state);
        issue(PINS_HALT, 12'h000, burst_halt_cmd);
        check_state("bank0", bank_active, bank0_state);
        issue(PINS_WRITE, 12'h422, write_cmd);
        check_state("bank0", writing_autoclose_state, bank0_state);
        check_val("col_addr", 12'h022, 12'(col_addr));
        issue(PINS_NOP, 12'hfff, idle_cmd);
        issue(PINS_DESELECT, 12'hfff, deselect_cmd);
        check_state("bank0", writing_autoclose_state, bank0_state);
        check_state("bank1", bank_idle, bank1_state);
        issue(PINS_CLOSE, 12'h400, all_banks_close_cmd);
        check_state("bank0", bank_idle, bank0_state);
    endtask : test_write_halt

    // Mode reloads with both banks idle: two reserved settings, then a legal full-page one.
    task automatic test_mode_reload;
        issue(PINS_MODE, 12'h00b, mode_load_cmd);
        check_val("mode_code", 12'h00b, mode_code);
        check_val("mode_reserved", 12'h001, 12'(mode_reserved));
        issue(PINS_MODE, 12'h02f, mode_load_cmd);
        check_val("mode_reserved", 12'h001, 12'(mode_reserved));
        issue(PINS_MODE, 12'h027, mode_load_cmd);
        check_val("read_latency", 12'(LAT_CLK_2), 12'(read_latency));
        check_val("burst_len", 12'(BURST_PAGE), 12'(burst_len));
        check_val("burst_interleaved", 12'h000, 12'(burst_interleaved));
        check_val("single_write", 12'h000, 12'(single_write));
        check_val("mode_reserved", 12'h000, 12'(mode_reserved));
    endtask : test_mode_reload

    // The wake-up edge of clock enable carries a row open that must be taken at once.
    task automatic test_sleep;
        @(negedge sys_clk);
        user_cke = 1'b0;
        repeat (3) @(negedge sys_clk);
        check_val("cke", 12'h000, 12'(link.cke));
        check_state("bank1", bank_idle, bank1_state);
        user_cke = 1'b1;
        user_valid = 1'b1;
        user_pins = PINS_ROW_OPEN;
        user_addr = 12'h812;
        @(negedge sys_clk);
        user_valid = 1'b0;
        user_pins = PINS_NOP;
        repeat (3) @(negedge sys_clk);
        check_val("cke", 12'h001, 12'(link.cke));
        check_state("bank1", bank_active, bank1_state);
        check_val("protocol_error", 12'h000, 12'(protocol_error));
    endtask : test_sleep

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge sys_clk);
        srst = 1'b0;
        test_init();
        test_open_read();
        test_close_one();
        test_write_halt();
        test_mode_reload();
        test_sleep();
        complete_run();
    end

    // The whole run needs about 125 cycles, so this leaves a wide margin.
    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end
endmodule : sdram_command_bank_state_test
